// ### sarcc_afe_model.sv
// Behavioural analog front end that answers the comparator queries of the converter.
`timescale 1ns/10ps
module sarcc_afe_model (
  input wire logic clk, // Block clock.
  input wire logic array_sw, // Array switch, high closed.
  input wire logic dummy_sw, // Dummy switch, high closed.
  input wire logic [15:0] dac_bits, // Trial code on the array.
  input wire logic [15:0] vin, // Input level as an ideal code.
  output logic comparator // High while the trial code is not above the held input.
);
  logic [15:0] held = 16'h0000;

  // The sample follows the input only while both switches are closed.
  always @(posedge clk) begin
    if (array_sw && dummy_sw) begin
      held <= vin;
    end
  end

  assign comparator = (dac_bits <= held);
endmodule

// ### sarcc_pkg.sv
// Package of constants and types for the SAR conversion control block.
package sarcc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACQ_TIME_NS = 1000;
  localparam int SETTLE_TIME_NS = 150;
  localparam logic [4:0] ACQ_CYCLES =
    5'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] SETTLE_CYCLES =
    2'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_MAX = 16'hFFFF;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam logic [3:0] MSB_INDEX = 4'hF;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h14;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_OVER_BIT = 1;
  localparam int INT_UNDER_BIT = 2;
  localparam int INT_ABORT_BIT = 3;
  localparam logic [3:0] RESET_INT_ENABLE = 4'h0;

  // ****************************************
  // Synchronised pin positions
  // ****************************************
  localparam int PIN_START = 0;
  localparam int PIN_CODING = 1;
  localparam int PIN_SLEEP = 2;
  localparam int PIN_ABORT = 3;
  localparam int PIN_COMP = 4;
  localparam int PIN_OVER = 5;
  localparam int PIN_UNDER = 6;
  localparam int PIN_COUNT = 7;

  typedef enum logic [1:0] {
    SARCC_ACQ = 2'b00,
    SARCC_ARMED = 2'b01,
    SARCC_CONV = 2'b10,
    SARCC_FINISH = 2'b11
  } sarcc_phase_type;

  typedef struct packed {
    logic [6:0] meta;
    logic [6:0] stable;
  } sarcc_sync_type;

  typedef struct packed {
    sarcc_phase_type phase;
    logic [4:0] acq_cnt;
    logic [3:0] bit_idx;
    logic [1:0] settle_cnt;
    logic [15:0] sar;
    logic [15:0] raw;
    logic [15:0] result;
    logic busy;
    logic sw_closed;
    logic [3:0] int_status;
    logic [3:0] int_enable;
    logic sw_sleep;
    logic irq;
    logic [31:0] prdata;
    logic pslverr;
  } sarcc_state_type;

endpackage

// ### sarcc_sync.sv
// Two-flop synchroniser for the asynchronous pins of the conversion control block.
`timescale 1ns/10ps
module sarcc_sync (
  input wire logic CLK, // Block clock.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic [6:0] ASYNC_IN, // Pins from outside the clock domain.
  output logic [6:0] SYNC_OUT // Synchronised copies.
);
  sarcc_pkg::sarcc_sync_type st;
  sarcc_pkg::sarcc_sync_type next_st;

  always_comb begin
    next_st.meta = ASYNC_IN;
    next_st.stable = st.meta;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign SYNC_OUT = st.stable;
endmodule

// ### sarcc_top.sv
// Control logic of a 16-bit successive-approximation converter with an APB register file.
`timescale 1ns/10ps
module sarcc_top (
  input wire logic CLK, // Block clock, 20 MHz.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic CONVERT_START_N, // Convert start pin, active low.
  input wire logic CODING_SELECT, // High for straight binary, low for twos complement.
  input wire logic SLEEP_REQUEST, // Power-down request pin, active high.
  input wire logic CONVERTER_RESET, // Converter reset pin, active high.
  input wire logic COMPARATOR, // Comparator decision, high keeps the trial bit.
  input wire logic OVER_RANGE, // Analog overrange detector.
  input wire logic UNDER_RANGE, // Analog underrange detector.
  output logic ARRAY_SAMPLE_SWITCH, // Array sampling switch, high closed.
  output logic DUMMY_SAMPLE_SWITCH, // Dummy sampling switch, high closed.
  output logic [15:0] DAC_BITS, // Array element switches, high to reference.
  output logic BUSY, // Conversion in progress.
  output logic [15:0] RESULT, // Formatted conversion result.
  output logic IRQ, // Level interrupt.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB enable.
  input wire logic PWRITE, // APB direction.
  input wire logic [7:0] PADDR, // APB byte address.
  input wire logic [31:0] PWDATA, // APB write data.
  output logic [31:0] PRDATA, // APB read data.
  output logic PREADY, // APB ready.
  output logic PSLVERR // APB error.
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [6:0] pins_s;

  sarcc_sync u_sync (
    .CLK(CLK),
    .SRST(SRST),
    .ASYNC_IN({UNDER_RANGE, OVER_RANGE, COMPARATOR, CONVERTER_RESET,
               SLEEP_REQUEST, CODING_SELECT, CONVERT_START_N}),
    .SYNC_OUT(pins_s)
  );

  logic start_s;
  logic coding_s;
  logic abort_s;
  logic comp_s;
  logic over_s;
  logic under_s;
  logic sleep_eff;
  logic apb_setup;
  logic apb_write;
  logic sw_start;
  logic start_req;
  logic conv_done;

  assign start_s = pins_s[sarcc_pkg::PIN_START];
  assign coding_s = pins_s[sarcc_pkg::PIN_CODING];
  assign abort_s = pins_s[sarcc_pkg::PIN_ABORT];
  assign comp_s = pins_s[sarcc_pkg::PIN_COMP];
  assign over_s = pins_s[sarcc_pkg::PIN_OVER];
  assign under_s = pins_s[sarcc_pkg::PIN_UNDER];
  assign apb_setup = PSEL && !PENABLE;
  assign apb_write = PSEL && PENABLE && PWRITE;
  assign sw_start = apb_write && (PADDR == sarcc_pkg::ADDR_CTRL)
                    && PWDATA[sarcc_pkg::CTRL_START_BIT];

  // ****************************************
  // State
  // ****************************************
  sarcc_pkg::sarcc_state_type st;
  sarcc_pkg::sarcc_state_type next_st;

  localparam sarcc_pkg::sarcc_state_type STATE_RESET = '{
    phase: sarcc_pkg::SARCC_ACQ,
    acq_cnt: sarcc_pkg::ACQ_CYCLES,
    bit_idx: 4'h0,
    settle_cnt: 2'h0,
    sar: sarcc_pkg::CODE_MIN,
    raw: sarcc_pkg::CODE_MIN,
    result: sarcc_pkg::CODE_MIN,
    busy: 1'b0,
    sw_closed: 1'b1,
    int_status: 4'h0,
    int_enable: sarcc_pkg::RESET_INT_ENABLE,
    sw_sleep: 1'b0,
    irq: 1'b0,
    prdata: 32'h0,
    pslverr: 1'b0
  };

  assign sleep_eff = pins_s[sarcc_pkg::PIN_SLEEP] || st.sw_sleep;
  assign start_req = !start_s || sw_start;
  assign conv_done = (st.phase == sarcc_pkg::SARCC_FINISH) && !abort_s;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [3:0] new_int;
    logic [3:0] clr;
    new_int = 4'h0;
    clr = 4'h0;
    next_st = st;
    if (abort_s) begin
      // Converter reset drops back to a fresh acquisition; results and registers stay, except that the abort status bit is set if busy.
      next_st.phase = sarcc_pkg::SARCC_ACQ;
      next_st.acq_cnt = sarcc_pkg::ACQ_CYCLES;
      next_st.sar = sarcc_pkg::CODE_MIN;
      next_st.bit_idx = 4'h0;
      next_st.settle_cnt = 2'h0;
      new_int[sarcc_pkg::INT_ABORT_BIT] = st.busy;
    end else begin
      unique case (st.phase)
        sarcc_pkg::SARCC_ACQ: begin
          if (st.acq_cnt != 5'h00) begin
            next_st.acq_cnt = st.acq_cnt - 5'h01;
          end else begin
            next_st.phase = sarcc_pkg::SARCC_ARMED;
          end
        end
        sarcc_pkg::SARCC_ARMED: begin
          // A start level already low when armed starts at once.
          if (start_req && !sleep_eff) begin
            next_st.phase = sarcc_pkg::SARCC_CONV;
            next_st.sar = sarcc_pkg::CODE_MID;
            next_st.bit_idx = sarcc_pkg::MSB_INDEX;
            next_st.settle_cnt = sarcc_pkg::SETTLE_CYCLES;
          end
        end
        sarcc_pkg::SARCC_CONV: begin
          if (st.settle_cnt != 2'h0) begin
            next_st.settle_cnt = st.settle_cnt - 2'h1;
          end else begin
            next_st.sar[st.bit_idx] = comp_s;
            if (st.bit_idx == 4'h0) begin
              next_st.phase = sarcc_pkg::SARCC_FINISH;
            end else begin
              next_st.bit_idx = st.bit_idx - 4'h1;
              next_st.sar[st.bit_idx - 4'h1] = 1'b1;
              next_st.settle_cnt = sarcc_pkg::SETTLE_CYCLES;
            end
          end
        end
        sarcc_pkg::SARCC_FINISH: begin
          if (over_s) begin
            next_st.raw = sarcc_pkg::CODE_MAX;
          end else if (under_s) begin
            next_st.raw = sarcc_pkg::CODE_MIN;
          end else begin
            next_st.raw = st.sar;
          end
          if (coding_s) begin
            next_st.result = next_st.raw;
          end else begin
            next_st.result = {~next_st.raw[15], next_st.raw[14:0]};
          end
          next_st.phase = sarcc_pkg::SARCC_ACQ;
          next_st.acq_cnt = sarcc_pkg::ACQ_CYCLES;
          new_int[sarcc_pkg::INT_DONE_BIT] = 1'b1;
          new_int[sarcc_pkg::INT_OVER_BIT] = over_s;
          new_int[sarcc_pkg::INT_UNDER_BIT] = under_s && !over_s;
        end
      endcase
    end

    // Register writes take effect in the access cycle.
    if (apb_write) begin
      case (PADDR)
        sarcc_pkg::ADDR_CTRL: next_st.sw_sleep = PWDATA[sarcc_pkg::CTRL_SLEEP_BIT];
        sarcc_pkg::ADDR_INT_ENABLE: next_st.int_enable = PWDATA[3:0];
        sarcc_pkg::ADDR_INT_CLEAR: clr = PWDATA[3:0];
        default: clr = 4'h0;
      endcase
    end
    // A new event in the clearing cycle survives the clear.
    next_st.int_status = (st.int_status & ~clr) | new_int;
    next_st.irq = |(next_st.int_status & next_st.int_enable);

    // Read data and error are captured in the setup cycle.
    if (apb_setup) begin
      next_st.prdata = 32'h0;
      next_st.pslverr = 1'b0;
      case (PADDR)
        sarcc_pkg::ADDR_CTRL: next_st.prdata = {30'h0, st.sw_sleep, 1'b0};
        sarcc_pkg::ADDR_STATUS: next_st.prdata = {27'h0, st.sw_closed, sleep_eff,
                                                  st.phase, st.busy};
        sarcc_pkg::ADDR_RESULT: next_st.prdata = {16'h0, st.result};
        sarcc_pkg::ADDR_INT_STATUS: next_st.prdata = {28'h0, st.int_status};
        sarcc_pkg::ADDR_INT_ENABLE: next_st.prdata = {28'h0, st.int_enable};
        sarcc_pkg::ADDR_INT_CLEAR: next_st.prdata = 32'h0;
        default: next_st.pslverr = 1'b1;
      endcase
    end

    next_st.busy = (next_st.phase == sarcc_pkg::SARCC_CONV)
                   || (next_st.phase == sarcc_pkg::SARCC_FINISH);
    next_st.sw_closed = (next_st.phase == sarcc_pkg::SARCC_ACQ)
                        || (next_st.phase == sarcc_pkg::SARCC_ARMED);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ARRAY_SAMPLE_SWITCH = st.sw_closed;
  assign DUMMY_SAMPLE_SWITCH = st.sw_closed;
  assign DAC_BITS = st.sar;
  assign BUSY = st.busy;
  assign RESULT = st.result;
  assign IRQ = st.irq;
  assign PRDATA = st.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = st.pslverr;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_arm_and_go;
    (st.phase == sarcc_pkg::SARCC_ARMED) && start_req && !sleep_eff && !abort_s;
  endsequence

  sequence s_conv_open;
    BUSY && !ARRAY_SAMPLE_SWITCH && !DUMMY_SAMPLE_SWITCH;
  endsequence

  sequence s_run_free;
    $rose(BUSY) ##0 (!abort_s)[*8];
  endsequence

  a_track_closed:
    assert property ((st.phase == sarcc_pkg::SARCC_ACQ || st.phase == sarcc_pkg::SARCC_ARMED)
                     |-> ARRAY_SAMPLE_SWITCH && DUMMY_SAMPLE_SWITCH && !BUSY)
    else $error("Switches not closed while tracking.");

  a_start_convert:
    assert property (s_arm_and_go |=> s_conv_open)
    else $error("Conversion did not start on request.");

  a_msb_trial:
    assert property ($rose(BUSY) |-> DAC_BITS == sarcc_pkg::CODE_MID && !ARRAY_SAMPLE_SWITCH)
    else $error("First trial is not the MSB alone.");

  a_bit_step:
    assert property ((st.phase == sarcc_pkg::SARCC_CONV) && st.settle_cnt == 2'h0
                     && st.bit_idx != 4'h0 && !abort_s
                     |=> st.bit_idx == $past(st.bit_idx) - 4'h1
                         && st.settle_cnt == sarcc_pkg::SETTLE_CYCLES)
    else $error("Bit index did not step down by one.");

  a_busy_min:
    assert property (s_run_free |-> BUSY)
    else $error("Busy fell too early.");

  a_result_format:
    assert property (conv_done |=> RESULT == ($past(coding_s) ? st.raw
                                              : {~st.raw[15], st.raw[14:0]}))
    else $error("Result coding wrong.");

  a_over_clamp:
    assert property (conv_done && over_s |=> st.raw == sarcc_pkg::CODE_MAX && !BUSY)
    else $error("Overrange not clamped.");

  a_under_clamp:
    assert property (conv_done && under_s && !over_s |=> st.raw == sarcc_pkg::CODE_MIN)
    else $error("Underrange not clamped.");

  a_abort_conv:
    assert property (abort_s |=> !BUSY && st.acq_cnt == sarcc_pkg::ACQ_CYCLES
                     && st.phase == sarcc_pkg::SARCC_ACQ)
    else $error("Converter reset did not abort.");

  a_sleep_block:
    assert property ((st.phase == sarcc_pkg::SARCC_ARMED) && sleep_eff |=> !BUSY)
    else $error("Conversion started while asleep.");

  a_result_hold:
    assert property (!conv_done |=> $stable(RESULT))
    else $error("Result changed outside completion.");

  a_return_track:
    assert property ($fell(BUSY) |-> ARRAY_SAMPLE_SWITCH && DUMMY_SAMPLE_SWITCH
                     && st.phase == sarcc_pkg::SARCC_ACQ)
    else $error("Switches not reclosed after conversion.");

endmodule

// ### tb.sv
// Self-checking testbench of the SAR conversion control block.
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic [15:0] v;
    logic ov;
    logic un;
    logic cs;
    logic [15:0] exp;
  } sarcc_row_type;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start_n = 1'b1;
  logic coding = 1'b1;
  logic sleep = 1'b0;
  logic conv_rst = 1'b0;
  logic over = 1'b0;
  logic under = 1'b0;
  logic comp, sw_a, sw_d, busy, irq, pready, pslverr, err;
  logic [15:0] dac, result, last;
  logic [15:0] vin = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  int error_cnt = 0;
  int num_checks = 0;
  int len;
  int n;
  sarcc_row_type rows [10] = '{
    '{16'h8000, 1'b0, 1'b0, 1'b1, 16'h8000}, '{16'h8000, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{16'hFFFF, 1'b0, 1'b0, 1'b0, 16'h7FFF}, '{16'h0001, 1'b0, 1'b0, 1'b0, 16'h8001},
    '{16'h1234, 1'b0, 1'b0, 1'b1, 16'h1234}, '{16'h1234, 1'b1, 1'b0, 1'b1, 16'hFFFF},
    '{16'h1234, 1'b1, 1'b0, 1'b0, 16'h7FFF}, '{16'h1234, 1'b0, 1'b1, 1'b1, 16'h0000},
    '{16'h1234, 1'b0, 1'b1, 1'b0, 16'h8000}, '{16'h1234, 1'b1, 1'b1, 1'b1, 16'hFFFF}};

  always #25 clk = ~clk;

  sarcc_top sarcc_top_i (
    .CLK(clk), .SRST(srst), .CONVERT_START_N(start_n), .CODING_SELECT(coding),
    .SLEEP_REQUEST(sleep), .CONVERTER_RESET(conv_rst), .COMPARATOR(comp),
    .OVER_RANGE(over), .UNDER_RANGE(under), .ARRAY_SAMPLE_SWITCH(sw_a),
    .DUMMY_SAMPLE_SWITCH(sw_d), .DAC_BITS(dac), .BUSY(busy), .RESULT(result), .IRQ(irq),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  sarcc_afe_model sarcc_afe_model_i (
    .clk(clk), .array_sw(sw_a), .dummy_sw(sw_d), .dac_bits(dac), .vin(vin),
    .comparator(comp));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // APB transfer: setup, then access held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== lvl && n < lim);
  endtask

  task automatic convert(input logic [15:0] v, input logic ov, input logic un,
                         input logic cs, input logic hold);
    @(posedge clk);
    vin <= v;
    over <= ov;
    under <= un;
    coding <= cs;
    start_n <= 1'b0;
    wait_busy(1'b1, 100);
    chk(32'(busy), 32'h1, "busy rise");
    chk(32'({sw_a, sw_d}), 32'h0, "switches open");
    chk(32'(dac), 32'h8000, "first trial");
    chk(32'(result), 32'(last), "result held");
    if (!hold) begin
      @(posedge clk) start_n <= 1'b1;
    end
    len = 0;
    while (busy === 1'b1 && len < 100) begin
      @(negedge clk);
      len++;
    end
    chk(32'(len), 32'd65, "busy length");
    chk(32'({sw_a, sw_d}), 32'h3, "switches closed");
  endtask

  initial begin
    last = 16'h0000;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(32'({busy, sw_a, sw_d, irq}), 32'h6, "reset outputs");
    chk(32'(result), 32'h0, "reset result");
    chk(32'(dac), 32'h0, "reset trial bits");
    chk(32'({pready, pslverr}), 32'h2, "reset bus outputs");
    $display("test reset done");
    foreach (rows[i]) begin
      convert(rows[i].v, rows[i].ov, rows[i].un, rows[i].cs, 1'b0);
      chk(32'(result), 32'(rows[i].exp), "coded result");
      last = rows[i].exp;
    end
    $display("test rows done");
    convert(16'h4321, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(32'(result), 32'h4321, "held start result");
    last = 16'h4321;
    wait_busy(1'b1, 40);
    chk(32'(busy), 32'h1, "restart on low level");
    @(posedge clk) start_n <= 1'b1;
    wait_busy(1'b0, 100);
    $display("test held start done");
    apb(1'b1, 8'h14, 32'h0000_000F);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0, "status cleared");
    convert(16'h0100, 1'b0, 1'b0, 1'b1, 1'b0);
    last = 16'h0100;
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h1, "done status");
    chk(32'(irq), 32'h0, "masked irq");
    apb(1'b1, 8'h10, 32'h0000_0001);
    chk(32'(irq), 32'h1, "enabled irq");
    apb(1'b1, 8'h14, 32'h0000_0001);
    chk(32'(irq), 32'h0, "cleared irq");
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0, "clear reads zero");
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    $display("test irq done");
    repeat (30) @(posedge clk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_0100, "result register");
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_0012, "status armed");
    apb(1'b1, 8'h00, 32'h0000_0002);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_001A, "status asleep");
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0002, "control readback");
    apb(1'b1, 8'h00, 32'h0000_0003);
    chk(32'(busy), 32'h0, "register sleep blocks start");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0000_0001, "enable readback");
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0001);
    wait_busy(1'b1, 10);
    chk(32'(busy), 32'h1, "register start");
    wait_busy(1'b0, 100);
    chk(32'(result), 32'h0100, "register start result");
    $display("test register done");
    @(posedge clk);
    start_n <= 1'b0;
    vin <= 16'hABCD;
    wait_busy(1'b1, 100);
    @(posedge clk) start_n <= 1'b1;
    repeat (10) @(posedge clk);
    conv_rst <= 1'b1;
    wait_busy(1'b0, 6);
    chk(32'({busy, result}), 32'(last), "abort");
    @(posedge clk) conv_rst <= 1'b0;
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'(rd[3]), 32'h1, "abort status");
    $display("test abort done");
    @(posedge clk) start_n <= 1'b0;
    wait_busy(1'b1, 100);
    @(posedge clk);
    start_n <= 1'b1;
    sleep <= 1'b1;
    wait_busy(1'b0, 100);
    chk(32'(result), 32'hABCD, "finish under sleep");
    @(posedge clk) start_n <= 1'b0;
    repeat (60) @(negedge clk);
    chk(32'(busy), 32'h0, "sleep blocks start");
    @(posedge clk);
    start_n <= 1'b1;
    sleep <= 1'b0;
    $display("test sleep done");
    test_done;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end
endmodule
